// *** pkg/lal_pkg.sv ***
`default_nettype none
package lal_pkg;
	// Command/indication codes on the host time-division interface.
	localparam logic [3:0] CI_ACTIVATION_REQUEST = 4'h8;
	localparam logic [3:0] CI_FULL_ACTIVE_REPORT = 4'hc;
	localparam logic [3:0] CI_U_ONLY_ACTIVE_REPORT = 4'h7;
	localparam logic [3:0] CI_U_ONLY_REQUEST = 4'h7;
	localparam logic [3:0] CI_S_CONTROL_RELEASED = 4'hf;
	localparam logic [3:0] CI_LINE_IDLE_REPORT = 4'hf;
	localparam logic [3:0] CI_DEACT_REQUEST = 4'h0;
	localparam logic [3:0] CI_LOOP1_ACTIVATE_REQ = 4'ha;
	localparam logic [3:0] CI_CHIP_INIT_CMD = 4'h4;
	// Maintenance channel zero command bytes.
	localparam logic [7:0] MSG_CLOSE_FULL_LOOP = 8'h50;
	localparam logic [7:0] MSG_B1_LOOP = 8'h51;
	localparam logic [7:0] MSG_B2_LOOP = 8'h52;
	localparam logic [7:0] MSG_OPEN_ALL_LOOPS = 8'hff;
	// Register map, byte addresses.
	localparam logic [3:0] REG_LOOP_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CI_MON = 4'h8;
	// Loop control field positions.
	localparam int CTRL_LOOP1 = 0;
	localparam int CTRL_FULL = 1;
	localparam int CTRL_B1 = 2;
	localparam int CTRL_B2 = 3;
	localparam int CTRL_OPEN_ALL = 4;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Controller states.
	typedef enum logic [2:0] {
		ST_DEACT, ST_U_ONLY, ST_PEND_PERMIT, ST_WAIT_TE,
		ST_REPORT_UAI, ST_FULL, ST_S_DEACT, ST_LOOP1
	} lal_state_t;
	// Latched far-end loop requests.
	typedef struct packed {
		logic full;
		logic b1;
		logic b2;
	} lal_loop2_t;
	// One frame of user data, B and D channels travel together.
	typedef struct packed {
		logic [7:0] b1;
		logic [7:0] b2;
		logic [1:0] d;
	} lal_frame_t;
endpackage
`default_nettype wire

// *** hdl/lal_ci_sampler.sv ***
`timescale 1ns/10ps
`default_nettype none
module lal_ci_sampler
	import lal_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Host frame and raw code.
	input wire logic frameStrobe,
	input wire logic [3:0] ciIn,
	// Sampled code.
	output logic [3:0] ciCode,
	output logic ciNew
);
	logic [3:0] code_q, code_d;
	logic new_q, new_d;

	// Code is taken once per frame; a differing code is flagged as new.
	always_comb
	begin
		code_d = code_q;
		new_d = 1'b0;
		if (frameStrobe)
		begin
			code_d = ciIn;
			new_d = (ciIn != code_q); // [R19]
		end
	end

	// Reset value matches an idle line so nothing looks new at start.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			code_q <= CI_LINE_IDLE_REPORT;
			new_q <= 1'b0;
		end
		else
		begin
			code_q <= code_d;
			new_q <= new_d;
		end
	end

	assign ciCode = code_q;
	assign ciNew = new_q;
endmodule
`default_nettype wire

// *** hdl/lal_loop_path.sv ***
`timescale 1ns/10ps
`default_nettype none
module lal_loop_path
	import lal_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Control.
	input wire logic loop1Closed,
	// Data.
	input wire lal_frame_t dsData,
	input wire lal_frame_t rxLine,
	output lal_frame_t txLine,
	output lal_frame_t usData
);
	lal_frame_t tx_q, tx_d, us_q, us_d;

	// Both channels share one register stage, so B and D see equal delay.
	always_comb
	begin
		tx_d = dsData; // [R8] [R17] [R9]
		us_d = loop1Closed ? tx_q : rxLine; // [R12] [R9]
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_q <= '0;
			us_q <= '0;
		end
		else
		begin
			tx_q <= tx_d;
			us_q <= us_d;
		end
	end

	assign txLine = tx_q;
	assign usData = us_q;
endmodule
`default_nettype wire

// *** hdl/lal_line_ctrl.sv ***
// Contract
// [R1] Terminal INFO 1 with U active raises remote activity; treat as terminal request.
// [R2] Terminal request with U active: report activation request code 1000.
// [R3] Exchange keeping control must answer with activation request before proceeding.
// [R4] With control released, terminal activation completes without exchange confirmation.
// [R5] Terminal active: report 0111, then 1100; exchange applies 1100.
// [R6] Exchange clears S-enable by applying 0111 instead of 1100.
// [R7] S-only deactivation keeps U active; report 0111 once S is down.
// [R8] Every loopback is transparent; looped bits also continue onward.
// [R9] B and D channel data have equal delay in every loopback.
// [R10] Loopbacks are also controllable directly through the register set.
// [R11] Loop 1 closes nearest the line with 6 dB receive attenuation active.
// [R12] Loop 1 keeps transmitting, ignores receive pins, stays line-active.
// [R13] Loop 1 wanted: exchange resets, then holds code 1010 continuously.
// [R14] Exchange opens loop 1 by soft reset command or reset pin.
// [R15] Exchange requests loop 2 variants with maintenance channel zero commands.
// [R16] Loop 2 requests latch; B1 and B2 together; open-all clears them.
// [R17] Downstream data passes transparently whatever loop 2 variants are closed.
// [R18] Close complete loop is byte 50h, open all is byte FFh.
// [R19] Command input sampled once per host frame; a change is a new command.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module lal_line_ctrl
	import lal_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Host command/indication channel.
	input wire logic frameStrobe,
	input wire logic [3:0] ciIn,
	output logic [3:0] ciOut,
	// Host maintenance channel zero.
	input wire logic monValid,
	input wire logic [7:0] monByte,
	// Line status.
	input wire logic uActive,
	input wire logic sActivityFlag,
	input wire logic terminalActive,
	// Line control.
	output logic sEnableBit,
	output logic rxAtten6db,
	output logic loop1Closed,
	output lal_loop2_t loop2Req,
	// User data.
	input wire lal_frame_t dsData,
	input wire lal_frame_t rxLine,
	output lal_frame_t txLine,
	output lal_frame_t usData,
	// Register port.
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdata
);
	logic [3:0] ciCode;
	logic ciNew;
	lal_state_t state_q, state_d;
	logic released_q, released_d;
	logic [3:0] ciOut_q, ciOut_d;
	logic sEn_q, sEn_d;
	lal_loop2_t loop2_q, loop2_d;
	logic forceLoop1_q, forceLoop1_d;
	logic [7:0] rdata_q, rdata_d;
	logic initCmd, ctrlWr;

	////////////////////////////////////////////////////////////////////////
	// Submodules.

	lal_ci_sampler u_sampler (
		.clock(clock),
		.rst_n(rst_n),
		.frameStrobe(frameStrobe),
		.ciIn(ciIn),
		.ciCode(ciCode),
		.ciNew(ciNew)
	);

	lal_loop_path u_path (
		.clock(clock),
		.rst_n(rst_n),
		.loop1Closed(loop1Closed),
		.dsData(dsData),
		.rxLine(rxLine),
		.txLine(txLine),
		.usData(usData)
	);

	////////////////////////////////////////////////////////////////////////
	// Activation state machine.

	// The soft reset acts once it is sampled at a frame strobe as a new code, from any state.
	assign initCmd = ciNew && (ciCode == CI_CHIP_INIT_CMD); // [R14]

	// Most commands act only on a new code; the U-only request in ST_DEACT, the permit in ST_PEND_PERMIT
	// and the loop request act on the held code, the loop request staying applied to keep the loop closed.
	always_comb
	begin
		state_d = state_q;
		released_d = released_q;
		ciOut_d = ciOut_q;
		sEn_d = sEn_q;
		case (state_q)
			ST_DEACT:
			begin
				ciOut_d = CI_LINE_IDLE_REPORT;
				sEn_d = 1'b0;
				released_d = 1'b0;
				if (ciCode == CI_LOOP1_ACTIVATE_REQ || forceLoop1_q)
					state_d = ST_LOOP1; // [R13]
				else if (ciCode == CI_U_ONLY_REQUEST && uActive)
					state_d = ST_U_ONLY;
			end
			ST_U_ONLY:
			begin
				ciOut_d = CI_U_ONLY_ACTIVE_REPORT;
				sEn_d = 1'b0;
				if (ciNew && ciCode == CI_S_CONTROL_RELEASED)
					released_d = 1'b1;
				else if (ciNew && ciCode == CI_U_ONLY_REQUEST)
					released_d = 1'b0;
				if (ciNew && ciCode == CI_DEACT_REQUEST)
					state_d = ST_DEACT;
				else if (ciNew && ciCode == CI_ACTIVATION_REQUEST)
					state_d = ST_WAIT_TE;
				else if (sActivityFlag && uActive) // [R1]
					state_d = released_q ? ST_WAIT_TE : ST_PEND_PERMIT; // [R4]
			end
			ST_PEND_PERMIT:
			begin
				ciOut_d = CI_ACTIVATION_REQUEST; // [R2]
				if (ciNew && ciCode == CI_DEACT_REQUEST)
					state_d = ST_DEACT;
				else if (ciCode == CI_ACTIVATION_REQUEST)
					state_d = ST_WAIT_TE; // [R3]
			end
			ST_WAIT_TE:
			begin
				ciOut_d = CI_ACTIVATION_REQUEST;
				sEn_d = 1'b1;
				if (ciNew && ciCode == CI_DEACT_REQUEST)
					state_d = ST_DEACT;
				else if (terminalActive)
					state_d = ST_REPORT_UAI;
			end
			ST_REPORT_UAI:
			begin
				ciOut_d = CI_U_ONLY_ACTIVE_REPORT; // [R5]
				if (frameStrobe)
					state_d = ST_FULL;
			end
			ST_FULL:
			begin
				ciOut_d = CI_FULL_ACTIVE_REPORT; // [R5]
				sEn_d = 1'b1;
				if (ciNew && ciCode == CI_DEACT_REQUEST)
					state_d = ST_DEACT;
				else if (ciNew && ciCode == CI_U_ONLY_REQUEST)
				begin
					sEn_d = 1'b0; // [R6]
					released_d = 1'b0;
					state_d = ST_S_DEACT;
				end
			end
			ST_S_DEACT:
			begin
				// U stays up; the report waits until the terminal has gone.
				sEn_d = 1'b0;
				if (!terminalActive)
					state_d = ST_U_ONLY; // [R7]
			end
			ST_LOOP1:
			begin
				ciOut_d = CI_FULL_ACTIVE_REPORT; // [R12]
				sEn_d = 1'b0;
				if (ciCode != CI_LOOP1_ACTIVATE_REQ && !forceLoop1_q)
					state_d = ST_DEACT; // [R13]
			end
			default:
			begin
				state_d = ST_DEACT;
			end
		endcase
		if (initCmd)
		begin
			state_d = ST_DEACT; // [R14]
			sEn_d = 1'b0;
			released_d = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= ST_DEACT;
			released_q <= 1'b0;
			ciOut_q <= CI_LINE_IDLE_REPORT;
			sEn_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			released_q <= released_d;
			ciOut_q <= ciOut_d;
			sEn_q <= sEn_d;
		end
	end

	assign ciOut = ciOut_q;
	assign sEnableBit = sEn_q;
	assign loop1Closed = (state_q == ST_LOOP1); // [R11]
	assign rxAtten6db = loop1Closed; // [R11]

	////////////////////////////////////////////////////////////////////////
	// Loop 2 latches and direct register control.

	assign ctrlWr = regWrite && (regAddr == REG_LOOP_CTRL);

	// Sets win over the open-all clear when both land in one cycle.
	always_comb
	begin
		loop2_d = loop2_q;
		forceLoop1_d = forceLoop1_q;
		if ((monValid && monByte == MSG_OPEN_ALL_LOOPS) || initCmd)
			loop2_d = '0; // [R16] [R18]
		if (ctrlWr && regWdata[CTRL_OPEN_ALL])
			loop2_d = '0; // [R10]
		if (monValid && monByte == MSG_CLOSE_FULL_LOOP)
			loop2_d.full = 1'b1; // [R15] [R18]
		if (monValid && monByte == MSG_B1_LOOP)
			loop2_d.b1 = 1'b1; // [R15] [R16]
		if (monValid && monByte == MSG_B2_LOOP)
			loop2_d.b2 = 1'b1; // [R15] [R16]
		if (ctrlWr)
		begin
			loop2_d.full = loop2_d.full | regWdata[CTRL_FULL]; // [R10]
			loop2_d.b1 = loop2_d.b1 | regWdata[CTRL_B1];
			loop2_d.b2 = loop2_d.b2 | regWdata[CTRL_B2];
			forceLoop1_d = regWdata[CTRL_LOOP1]; // [R10]
		end
		if (initCmd)
			forceLoop1_d = 1'b0;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loop2_q <= '0;
			forceLoop1_q <= 1'b0;
		end
		else
		begin
			loop2_q <= loop2_d;
			forceLoop1_q <= forceLoop1_d;
		end
	end

	assign loop2Req = loop2_q;

	////////////////////////////////////////////////////////////////////////
	// Register read port; data stands one cycle after the strobe only.

	always_comb
	begin
		rdata_d = RESET_BYTE;
		if (regRead)
		begin
			case (regAddr)
				REG_LOOP_CTRL:
					rdata_d = {4'h0, loop2_q.b2, loop2_q.b1, loop2_q.full, forceLoop1_q};
				REG_STATUS:
					rdata_d = {2'h0, loop1Closed, released_q, sEn_q, 3'(state_q)};
				REG_CI_MON:
					rdata_d = {ciOut_q, ciCode};
				default:
					rdata_d = RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= RESET_BYTE;
		else
			rdata_q <= rdata_d;
	end

	assign regRdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence s_te_request;
		state_q == ST_U_ONLY && sActivityFlag && uActive && !released_q && !ciNew;
	endsequence

	sequence s_report_steps;
		state_q == ST_REPORT_UAI ##1 ciOut == CI_U_ONLY_ACTIVE_REPORT;
	endsequence

	a_notify_request: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
		s_te_request |-> ##2 ciOut == CI_ACTIVATION_REQUEST)
		else $error("activation request not reported");

	a_held_for_permit: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
		state_q == ST_PEND_PERMIT && ciCode != CI_ACTIVATION_REQUEST && !initCmd
		&& !ciNew |=> state_q == ST_PEND_PERMIT)
		else $error("activation went on without permission");

	a_released_direct: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
		state_q == ST_U_ONLY && sActivityFlag && uActive && released_q && !ciNew
		|=> state_q == ST_WAIT_TE)
		else $error("released activation did not proceed");

	a_uai_then_ai: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
		s_report_steps ##0 (frameStrobe && !initCmd) |=> ##1 ciOut == CI_FULL_ACTIVE_REPORT)
		else $error("full active not reported after u only");

	a_s_only_down: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
		state_q == ST_FULL && ciNew && ciCode == CI_U_ONLY_REQUEST && !initCmd
		|=> !sEnableBit && state_q == ST_S_DEACT)
		else $error("s only deactivation failed");

	// The report code trails the state by one register stage, so check from the second cycle.
	a_loop1_atten: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
		loop1Closed && $past(loop1Closed) |-> rxAtten6db && ciOut == CI_FULL_ACTIVE_REPORT)
		else $error("loop one without attenuation");

	a_loop1_path: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
		loop1Closed && $past(loop1Closed) |=> usData == $past(txLine))
		else $error("loop one did not return transmit data");

	a_transparent: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
		1'b1 |=> txLine == $past(dsData))
		else $error("downstream data not transparent");

	a_open_all: assert property (@(posedge clock) disable iff (!rst_n) // [R16]
		monValid && monByte == MSG_OPEN_ALL_LOOPS && !ctrlWr |=> loop2Req == '0)
		else $error("loops not opened");

	a_sample_frame: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
		!frameStrobe |=> !ciNew)
		else $error("new command outside a frame");
endmodule
`default_nettype wire

// *** bench/lal_exchange_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module lal_exchange_model
	import lal_pkg::*;
#(
	parameter int FRAME_LEN = 8
)
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Code chosen by the bench.
	input wire logic [3:0] cmd,
	// Host channel towards the block.
	output logic frameStrobe,
	output logic [3:0] ciIn,
	output logic monValid,
	output logic [7:0] monByte
);
	import lal_pkg::*;
	logic [7:0] frameCnt_q;
	////////////////////////////////////////
	// The code is swapped only after a strobe, so it is stable for a whole frame.
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			frameCnt_q <= 8'h00;
			frameStrobe <= 1'b0;
			ciIn <= CI_LINE_IDLE_REPORT;
		end
		else
		begin
			frameCnt_q <= (frameCnt_q == 8'(FRAME_LEN - 1)) ? 8'h00 : frameCnt_q + 8'h01;
			frameStrobe <= (frameCnt_q == 8'(FRAME_LEN - 1));
			if (frameStrobe)
				ciIn <= cmd;
		end
	end
	// A released byte lane shows the inverse, so a stale value never looks valid.
	initial
	begin
		monValid = 1'b0;
		monByte = 8'h00;
	end
	// One maintenance byte per call, held for exactly one sampled edge.
	task automatic sendMon(input logic [7:0] b);
		@(posedge clock);
		monValid <= 1'b1;
		monByte <= b;
		@(posedge clock);
		monValid <= 1'b0;
		monByte <= ~b;
	endtask
endmodule
`default_nettype wire

// *** bench/lal_line_ctrl_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module lal_line_ctrl_tb;
	import lal_pkg::*;
	logic clock, rst_n, frameStrobe, monValid, uActive, sActivityFlag, terminalActive;
	logic sEnableBit, rxAtten6db, loop1Closed, regWrite, regRead, rdPend, dataOn, prevLoop;
	logic [3:0] ciIn, ciOut, cmd, regAddr;
	logic [7:0] monByte, regWdata, regRdata;
	logic [7:0] expQ[$];
	logic [31:0] seed = 32'h5b2f3ce0;
	lal_loop2_t loop2Req;
	lal_frame_t dsData = '0, rxLine = '0, txLine, usData, prevDs, prevRx;
	int miscompares = 0, numChecks = 0;
	////////////////////////////////////////
	lal_exchange_model u_xchg (.clock(clock), .rst_n(rst_n), .cmd(cmd),
		.frameStrobe(frameStrobe), .ciIn(ciIn), .monValid(monValid), .monByte(monByte));
	lal_line_ctrl u_dut (.clock(clock), .rst_n(rst_n), .frameStrobe(frameStrobe),
		.ciIn(ciIn), .ciOut(ciOut), .monValid(monValid), .monByte(monByte),
		.uActive(uActive), .sActivityFlag(sActivityFlag), .terminalActive(terminalActive),
		.sEnableBit(sEnableBit), .rxAtten6db(rxAtten6db), .loop1Closed(loop1Closed),
		.loop2Req(loop2Req), .dsData(dsData), .rxLine(rxLine), .txLine(txLine),
		.usData(usData), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata));
	////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic reportAndStop;
		$display("checks %0d mismatches %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Ends three edges after the n-th strobe, when the reply code has settled.
	task automatic frames(input int n);
		repeat (n) @(posedge clock iff frameStrobe);
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask
	task automatic ci(input logic [3:0] c);
		@(posedge clock);
		cmd <= c;
	endtask
	task automatic regWr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic regRd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		expQ.push_back(e);
		@(posedge clock);
		regRead <= 1'b0;
	endtask
	////////////////////////////////////////
	// Clock at 200 MHz.
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	// Random frames go in every cycle; the previous ones are kept for comparison.
	always @(posedge clock)
	begin
		rdPend <= regRead;
		prevDs <= dsData;
		prevRx <= rxLine;
		prevLoop <= loop1Closed;
		seed <= xs(seed);
		dsData <= lal_frame_t'(seed[17:0]);
		rxLine <= lal_frame_t'(seed[31:14]);
	end
	// Read data are only valid in the cycle after the strobe, so compare mid-cycle.
	always @(negedge clock)
	begin
		if (rst_n && rdPend)
			chk(18'(regRdata), 18'(expQ.pop_front()));
		else if (rst_n)
			chk(18'(regRdata), 18'h0);
		if (rst_n && dataOn)
		begin
			chk(txLine, prevDs);
			if (!prevLoop && !loop1Closed)
				chk(usData, prevRx);
		end
	end
	// Watchdog well beyond the expected run of a few hundred cycles.
	initial
	begin
		repeat (20000) @(posedge clock);
		miscompares++;
		reportAndStop();
	end
	// Main sequence.
	initial
	begin
		rst_n = 1'b0;
		cmd = CI_LINE_IDLE_REPORT;
		{uActive, sActivityFlag, terminalActive, regWrite, regRead, dataOn} = 6'h00;
		regAddr = 4'h0;
		regWdata = 8'h00;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		chk(ciOut, CI_LINE_IDLE_REPORT);
		chk({sEnableBit, loop2Req}, 4'h0);
		@(posedge clock) dataOn <= 1'b1;
		regRd(REG_LOOP_CTRL, RESET_BYTE);
		// Exchange keeps control of the terminal activation.
		@(posedge clock) uActive <= 1'b1;
		ci(CI_U_ONLY_REQUEST);
		frames(2);
		chk(ciOut, CI_U_ONLY_ACTIVE_REPORT);
		@(posedge clock) sActivityFlag <= 1'b1;
		frames(3);
		chk(ciOut, CI_ACTIVATION_REQUEST);
		chk(sEnableBit, 1'b0);
		ci(CI_ACTIVATION_REQUEST);
		frames(2);
		chk(sEnableBit, 1'b1);
		@(posedge clock) terminalActive <= 1'b1;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk(ciOut, CI_U_ONLY_ACTIVE_REPORT);
		frames(1);
		chk(ciOut, CI_FULL_ACTIVE_REPORT);
		ci(CI_FULL_ACTIVE_REPORT);
		frames(2);
		chk({sEnableBit, ciOut}, {1'b1, CI_FULL_ACTIVE_REPORT});
		// Only the terminal side is taken down.
		ci(CI_U_ONLY_REQUEST);
		frames(2);
		chk(sEnableBit, 1'b0);
		@(posedge clock) {terminalActive, sActivityFlag} <= 2'b00;
		frames(2);
		chk(ciOut, CI_U_ONLY_ACTIVE_REPORT);
		// Control released: no permit is needed.
		ci(CI_S_CONTROL_RELEASED);
		frames(2);
		@(posedge clock) sActivityFlag <= 1'b1;
		frames(3);
		chk(sEnableBit, 1'b1);
		// A deactivation request takes the line back to idle from every state except ST_REPORT_UAI, ST_S_DEACT and a register-forced ST_LOOP1.
		ci(CI_DEACT_REQUEST);
		frames(2);
		chk({sEnableBit, ciOut}, {1'b0, CI_LINE_IDLE_REPORT});
		// Analog loop from the deactivated state, then opened by soft reset.
		@(posedge clock) sActivityFlag <= 1'b0;
		ci(CI_CHIP_INIT_CMD);
		frames(2);
		ci(CI_LOOP1_ACTIVATE_REQ);
		frames(2);
		chk({loop1Closed, rxAtten6db}, 2'b11);
		frames(2);
		chk(loop1Closed, 1'b1);
		ci(CI_CHIP_INIT_CMD);
		frames(2);
		chk({loop1Closed, rxAtten6db}, 2'b00);
		ci(CI_LINE_IDLE_REPORT);
		frames(2);
		// Far-end loop requests latch and open together.
		u_xchg.sendMon(MSG_CLOSE_FULL_LOOP);
		@(negedge clock) chk(loop2Req, 3'b100);
		u_xchg.sendMon(MSG_B1_LOOP);
		u_xchg.sendMon(MSG_B2_LOOP);
		@(negedge clock) chk(loop2Req, 3'b111);
		u_xchg.sendMon(MSG_OPEN_ALL_LOOPS);
		@(negedge clock) chk(loop2Req, 3'b000);
		// Direct control through the registers, and an unmapped address.
		regWr(REG_LOOP_CTRL, 8'h0f);
		repeat (2) @(posedge clock);
		@(negedge clock) chk({loop1Closed, loop2Req}, 4'b1111);
		regRd(REG_LOOP_CTRL, 8'h0f);
		regRd(REG_STATUS, {2'b00, 1'b1, 1'b0, 1'b0, 3'(ST_LOOP1)});
		regRd(REG_CI_MON, {CI_FULL_ACTIVE_REPORT, CI_LINE_IDLE_REPORT});
		regWr(REG_LOOP_CTRL, 8'h10);
		regRd(REG_LOOP_CTRL, 8'h00);
		regWr(4'hc, 8'hff);
		regRd(4'hc, 8'h00);
		regRd(REG_LOOP_CTRL, 8'h00);
		repeat (4) @(posedge clock);
		reportAndStop();
	end
endmodule
`default_nettype wire
